//--- pbs_pkg.sv
// constants and types for the status, alert and telemetry command bank
// assumes a separate protocol engine delivers decoded command transactions
package pbs_pkg;
	// command codes
	localparam logic [7:0] CMD_CLEAR = 8'h03;
	localparam logic [7:0] CMD_MASK = 8'h1B;
	localparam logic [7:0] CMD_BYTE = 8'h78;
	localparam logic [7:0] CMD_WORD = 8'h79;
	localparam logic [7:0] CMD_VOUT_ST = 8'h7A;
	localparam logic [7:0] CMD_IOUT_ST = 8'h7B;
	localparam logic [7:0] CMD_TEMP_ST = 8'h7D;
	localparam logic [7:0] CMD_CML_ST = 8'h7E;
	localparam logic [7:0] CMD_MFR_ST = 8'h80;
	localparam logic [7:0] CMD_FAN_ST = 8'h81;
	localparam logic [7:0] CMD_RD_VOUT = 8'h8B;
	localparam logic [7:0] CMD_RD_IOUT = 8'h8C;
	localparam logic [7:0] CMD_RD_TEMP = 8'h8D;
	localparam logic [7:0] CMD_RD_FAN = 8'h90;
	localparam logic [7:0] CMD_RD_POUT = 8'h96;
	// mask slots, in table order
	localparam int NUM_MASK = 8;
	localparam logic [2:0] MI_BYTE = 3'h0;
	localparam logic [2:0] MI_WORD = 3'h1;
	localparam logic [2:0] MI_VOUT = 3'h2;
	localparam logic [2:0] MI_IOUT = 3'h3;
	localparam logic [2:0] MI_TEMP = 3'h4;
	localparam logic [2:0] MI_CML = 3'h5;
	localparam logic [2:0] MI_MFR = 3'h6;
	localparam logic [2:0] MI_FAN = 3'h7;
	localparam logic [7:0] MASK_RST_BYTE = 8'h02;
	localparam logic [7:0] MASK_RST_CML = 8'hFF;
	localparam logic [7:0] MASK_RST_OTHER = 8'h00;
	// implemented bits of each detail register
	localparam logic [7:0] IMPL_VOUT = 8'h80;
	localparam logic [7:0] IMPL_IOUT = 8'hA0;
	localparam logic [7:0] IMPL_TEMP = 8'h80;
	localparam logic [7:0] IMPL_CML = 8'hEA;
	localparam logic [7:0] IMPL_MFR = 8'h07;
	localparam logic [7:0] IMPL_FAN = 8'h80;
	localparam logic [7:0] ST_RST = 8'h00;
	// bit positions
	localparam int B_TOP = 7;
	localparam int B_RATED = 5;
	localparam int B_OV = 5;
	localparam int B_OC = 4;
	localparam int B_TSUM = 2;
	localparam int B_CSUM = 1;
	localparam int B_INVCMD = 7;
	localparam int B_INVDAT = 6;
	localparam int B_PEC = 5;
	localparam int B_PROC = 3;
	localparam int B_COMOTH = 1;
	localparam int B_VSUM = 7;
	localparam int B_ISUM = 6;
	localparam int B_MSUM = 4;
	localparam int B_FSUM = 2;
	localparam int B_OTHER = 0;
	// transaction kinds from the protocol engine
	typedef enum logic [2:0] {OP_SEND, OP_WR_BYTE, OP_WR_WORD, OP_RD,
		OP_MASK_RD} pbs_op_t;
endpackage

//--- pbs_status_bank.sv
// status, alert mask and telemetry command bank
// assumes a protocol engine on link_clk_i delivering one decoded
// transaction at a time; fault inputs and readings are on clk_sys_i
`timescale 1ns/10ps
`default_nettype none
module pbs_status_bank
(
	// system clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// link side, on link clock
	input wire logic link_clk_i,
	input wire logic req_valid_i,
	input wire pbs_pkg::pbs_op_t req_op_i,
	input wire logic [7:0] req_code_i,
	input wire logic [15:0] req_data_i,
	input wire logic req_pec_err_i,
	output logic req_ready_o,
	output logic ans_valid_o,
	output logic ans_ok_o,
	output logic [15:0] ans_data_o,
	// fault events, system clock
	input wire logic ov_fault_i,
	input wire logic oc_fault_i,
	input wire logic over_rated_i,
	input wire logic ot_fault_i,
	input wire logic fan_fault_i,
	input wire logic derate_stop_i,
	input wire logic pulse_stop_i,
	input wire logic sense_stop_i,
	input wire logic proc_fault_i,
	input wire logic other_fault_i,
	// readings, system clock
	input wire logic [15:0] vout_i,
	input wire logic [15:0] iout_i,
	input wire logic [15:0] pout_i,
	input wire logic [15:0] fan_speed_i,
	input wire logic [15:0] temp_i,
	// alert pin, open drain
	output logic alert_o,
	output logic alert_oe_n_o
);
	import pbs_pkg::*;
	// ==========================================================
	// link domain: request capture and answer
	typedef enum {LK_IDLE, LK_WAIT} pbs_lk_state_t;
	pbs_lk_state_t lk_state_reg;
	logic [7:0] lk_code_reg;
	pbs_op_t lk_op_reg;
	logic [15:0] lk_data_reg;
	logic lk_pec_reg;
	logic lk_req_tgl_reg;
	logic lk_busy_tgl_reg;
	logic [1:0] lk_rsp_sync_reg;
	logic lk_rsp_seen_reg;
	logic lk_ans_valid_reg;
	logic lk_ans_ok_reg;
	logic [15:0] lk_ans_data_reg;
	logic sy_rsp_tgl_reg;
	logic sy_rsp_ok_reg;
	logic [15:0] sy_rsp_data_reg;
	wire lk_rsp_edge = lk_rsp_sync_reg[1] ^ lk_rsp_seen_reg;
	wire lk_take = req_valid_i && (lk_state_reg == LK_IDLE);
	wire lk_reject = req_valid_i && (lk_state_reg == LK_WAIT);

	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lk_state_reg <= LK_IDLE;
			lk_code_reg <= 8'h00;
			lk_op_reg <= OP_SEND;
			lk_data_reg <= 16'h0000;
			lk_pec_reg <= 1'b0;
			lk_req_tgl_reg <= 1'b0;
			lk_busy_tgl_reg <= 1'b0;
		end
		else
		begin
			case (lk_state_reg)
				LK_IDLE:
					if (lk_take)
					begin
						lk_code_reg <= req_code_i;
						lk_op_reg <= req_op_i;
						lk_data_reg <= req_data_i;
						lk_pec_reg <= req_pec_err_i;
						lk_req_tgl_reg <= ~lk_req_tgl_reg;
						lk_state_reg <= LK_WAIT;
					end
				LK_WAIT:
					if (lk_rsp_edge)
						lk_state_reg <= LK_IDLE;
				default:
					lk_state_reg <= LK_IDLE;
			endcase
			if (lk_reject)
				lk_busy_tgl_reg <= ~lk_busy_tgl_reg;
		end
	end

	// answer words are held by the system side until the toggle lands
	always_ff @(posedge link_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lk_rsp_sync_reg <= 2'b00;
			lk_rsp_seen_reg <= 1'b0;
			lk_ans_valid_reg <= 1'b0;
			lk_ans_ok_reg <= 1'b0;
			lk_ans_data_reg <= 16'h0000;
		end
		else
		begin
			lk_rsp_sync_reg <= {lk_rsp_sync_reg[0], sy_rsp_tgl_reg};
			lk_rsp_seen_reg <= lk_rsp_sync_reg[1];
			lk_ans_valid_reg <= lk_rsp_edge;
			if (lk_rsp_edge)
			begin
				lk_ans_ok_reg <= sy_rsp_ok_reg;
				lk_ans_data_reg <= sy_rsp_data_reg;
			end
		end
	end

	assign req_ready_o = (lk_state_reg == LK_IDLE);
	assign ans_valid_o = lk_ans_valid_reg;
	assign ans_ok_o = lk_ans_ok_reg;
	assign ans_data_o = lk_ans_data_reg;
	// ==========================================================
	// system domain: event crossing
	logic [2:0] sy_req_sync_reg;
	logic [2:0] sy_busy_sync_reg;

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sy_req_sync_reg <= 3'b000;
			sy_busy_sync_reg <= 3'b000;
		end
		else
		begin
			sy_req_sync_reg <= {sy_req_sync_reg[1:0], lk_req_tgl_reg};
			sy_busy_sync_reg <= {sy_busy_sync_reg[1:0], lk_busy_tgl_reg};
		end
	end

	wire req_edge = sy_req_sync_reg[2] ^ sy_req_sync_reg[1];
	wire busy_edge = sy_busy_sync_reg[2] ^ sy_busy_sync_reg[1];
	// ==========================================================
	// command decode
	function automatic logic mask_hit(input logic [7:0] c);
		mask_hit = (c == CMD_BYTE) || (c == CMD_WORD) ||
			(c == CMD_VOUT_ST) || (c == CMD_IOUT_ST) ||
			(c == CMD_TEMP_ST) || (c == CMD_CML_ST) ||
			(c == CMD_MFR_ST) || (c == CMD_FAN_ST);
	endfunction

	function automatic logic [2:0] mask_idx(input logic [7:0] c);
		case (c)
			CMD_BYTE: mask_idx = MI_BYTE;
			CMD_WORD: mask_idx = MI_WORD;
			CMD_VOUT_ST: mask_idx = MI_VOUT;
			CMD_IOUT_ST: mask_idx = MI_IOUT;
			CMD_TEMP_ST: mask_idx = MI_TEMP;
			CMD_CML_ST: mask_idx = MI_CML;
			CMD_MFR_ST: mask_idx = MI_MFR;
			default: mask_idx = MI_FAN;
		endcase
	endfunction

	function automatic logic tele_hit(input logic [7:0] c);
		tele_hit = (c == CMD_RD_VOUT) || (c == CMD_RD_IOUT) ||
			(c == CMD_RD_TEMP) || (c == CMD_RD_FAN) ||
			(c == CMD_RD_POUT);
	endfunction

	wire [7:0] code = lk_code_reg;
	wire [7:0] mcode = lk_data_reg[7:0];
	wire known = mask_hit(code) || tele_hit(code) ||
		(code == CMD_CLEAR) || (code == CMD_MASK);
	wire acc = req_edge && !lk_pec_reg;
	wire do_clear = acc && (lk_op_reg == OP_SEND) && (code == CMD_CLEAR);
	wire wr_byte = acc && (lk_op_reg == OP_WR_BYTE) && mask_hit(code) &&
		(code != CMD_WORD);
	wire wr_word = acc && (lk_op_reg == OP_WR_WORD) && (code == CMD_WORD);
	wire mask_wr = acc && (lk_op_reg == OP_WR_WORD) && (code == CMD_MASK);
	wire mask_rd = acc && (lk_op_reg == OP_MASK_RD) && (code == CMD_MASK);
	wire rd_ok = acc && (lk_op_reg == OP_RD) &&
		(mask_hit(code) || tele_hit(code));
	wire bad_data = (mask_wr || mask_rd) && !mask_hit(mcode);
	wire good = do_clear || wr_byte || wr_word || rd_ok ||
		((mask_wr || mask_rd) && !bad_data);
	wire bad_cmd = acc && !known;
	wire bad_other = acc && known && !good && !bad_data;
	wire pec_fail = req_edge && lk_pec_reg;
	// ==========================================================
	// status registers
	logic [7:0] vout_reg;
	logic [7:0] iout_reg;
	logic [7:0] temp_reg;
	logic [7:0] cml_reg;
	logic [7:0] mfr_reg;
	logic [7:0] fan_reg;
	logic busy_reg;
	logic other_reg;
	logic [7:0] mask_reg [NUM_MASK];
	logic alert_reg;

	// write-one-clear with set winning
	function automatic logic [7:0] w1c(input logic [7:0] cur,
		input logic [7:0] set, input logic [7:0] clr, input logic all);
		w1c = ((all ? 8'h00 : (cur & ~clr)) | set);
	endfunction

	wire [7:0] clr_v = (wr_byte && code == CMD_VOUT_ST) ? mcode : 8'h00;
	wire [7:0] clr_i = (wr_byte && code == CMD_IOUT_ST) ? mcode : 8'h00;
	wire [7:0] clr_t = (wr_byte && code == CMD_TEMP_ST) ? mcode : 8'h00;
	wire [7:0] clr_c = (wr_byte && code == CMD_CML_ST) ? mcode : 8'h00;
	wire [7:0] clr_m = (wr_byte && code == CMD_MFR_ST) ? mcode : 8'h00;
	wire [7:0] clr_f = (wr_byte && code == CMD_FAN_ST) ? mcode : 8'h00;
	wire clr_busy = ((wr_byte && code == CMD_BYTE) || wr_word) &&
		mcode[B_TOP];
	wire clr_other = wr_word && lk_data_reg[8 + B_OTHER];
	wire [7:0] set_v = {ov_fault_i, 7'h00} & IMPL_VOUT;
	wire [7:0] set_i = {oc_fault_i, 1'b0, over_rated_i, 5'h00} & IMPL_IOUT;
	wire [7:0] set_t = {ot_fault_i, 7'h00} & IMPL_TEMP;
	wire [7:0] set_c = {bad_cmd, bad_data, pec_fail, 1'b0, proc_fault_i,
		1'b0, bad_other, 1'b0} & IMPL_CML;
	wire [7:0] set_m = {5'h00, derate_stop_i, pulse_stop_i,
		sense_stop_i} & IMPL_MFR;
	wire [7:0] set_f = {fan_fault_i, 7'h00} & IMPL_FAN;
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			vout_reg <= ST_RST;
			iout_reg <= ST_RST;
			temp_reg <= ST_RST;
			cml_reg <= ST_RST;
			mfr_reg <= ST_RST;
			fan_reg <= ST_RST;
			busy_reg <= 1'b0;
			other_reg <= 1'b0;
		end
		else
		begin
			vout_reg <= w1c(vout_reg, set_v, clr_v, do_clear);
			iout_reg <= w1c(iout_reg, set_i, clr_i, do_clear);
			temp_reg <= w1c(temp_reg, set_t, clr_t, do_clear);
			cml_reg <= w1c(cml_reg, set_c, clr_c, do_clear);
			mfr_reg <= w1c(mfr_reg, set_m, clr_m, do_clear);
			fan_reg <= w1c(fan_reg, set_f, clr_f, do_clear);
			busy_reg <= busy_edge || (busy_reg && !clr_busy &&
				!do_clear);
			other_reg <= other_fault_i || (other_reg && !clr_other &&
				!do_clear);
		end
	end

	// summaries track their detail registers
	wire [7:0] sum_byte = {busy_reg, 1'b0, vout_reg[B_TOP],
		iout_reg[B_TOP], 1'b0, |temp_reg, |cml_reg, 1'b0};
	wire [7:0] sum_hi = {|vout_reg, |iout_reg, 1'b0, |mfr_reg, 1'b0,
		|fan_reg, 1'b0, other_reg};
	wire [15:0] sum_word = {sum_hi, sum_byte};

	// ==========================================================
	// alert masks
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MASK; gi++)
		begin : g_mask
			localparam logic [7:0] RST = (gi == MI_BYTE) ? MASK_RST_BYTE :
				(gi == MI_CML) ? MASK_RST_CML : MASK_RST_OTHER;
			always_ff @(posedge clk_sys_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					mask_reg[gi] <= RST;
				else if (mask_wr && !bad_data && mask_idx(mcode) == gi)
					mask_reg[gi] <= lk_data_reg[15:8];
			end
		end
	endgenerate
	wire alert_next = |(sum_byte & ~mask_reg[MI_BYTE]) |
		|(sum_hi & ~mask_reg[MI_WORD]) |
		|(vout_reg & ~mask_reg[MI_VOUT]) |
		|(iout_reg & ~mask_reg[MI_IOUT]) |
		|(temp_reg & ~mask_reg[MI_TEMP]) |
		|(cml_reg & ~mask_reg[MI_CML]) |
		|(mfr_reg & ~mask_reg[MI_MFR]) |
		|(fan_reg & ~mask_reg[MI_FAN]);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			alert_reg <= 1'b0;
		else
			alert_reg <= alert_next;
	end

	assign alert_o = 1'b0;
	assign alert_oe_n_o = ~alert_reg;
	// ==========================================================
	// read answers
	logic [15:0] rd_val;
	always_comb
	begin
		case (code)
			CMD_BYTE: rd_val = {8'h00, sum_byte};
			CMD_WORD: rd_val = sum_word;
			CMD_VOUT_ST: rd_val = {8'h00, vout_reg};
			CMD_IOUT_ST: rd_val = {8'h00, iout_reg};
			CMD_TEMP_ST: rd_val = {8'h00, temp_reg};
			CMD_CML_ST: rd_val = {8'h00, cml_reg};
			CMD_MFR_ST: rd_val = {8'h00, mfr_reg};
			CMD_FAN_ST: rd_val = {8'h00, fan_reg};
			CMD_RD_VOUT: rd_val = vout_i;
			CMD_RD_IOUT: rd_val = iout_i;
			CMD_RD_POUT: rd_val = pout_i;
			CMD_RD_FAN: rd_val = fan_speed_i;
			CMD_RD_TEMP: rd_val = temp_i;
			default: rd_val = 16'h0000;
		endcase
	end

	wire [15:0] ans_val = mask_rd ? {8'h00, mask_reg[mask_idx(mcode)]} :
		(rd_ok ? rd_val : 16'h0000);

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sy_rsp_tgl_reg <= 1'b0;
			sy_rsp_ok_reg <= 1'b0;
			sy_rsp_data_reg <= 16'h0000;
		end
		else if (req_edge)
		begin
			sy_rsp_tgl_reg <= ~sy_rsp_tgl_reg;
			sy_rsp_ok_reg <= good;
			sy_rsp_data_reg <= ans_val;
		end
	end

	// ==========================================================
	// checks
	wire any_set = |{set_v, set_i, set_t, set_c, set_m, set_f,
		busy_edge, other_fault_i};
	wire all_zero = ({vout_reg, iout_reg, temp_reg, cml_reg, mfr_reg,
		fan_reg} == 48'h0) && !busy_reg && !other_reg;
	sequence s_clear_req;
		do_clear && !any_set;
	endsequence
	sequence s_quiet;
		!any_set && !mask_wr;
	endsequence
	a_clear_all: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_clear_req ##0 s_quiet |=> all_zero ##0 s_quiet |=> alert_oe_n_o)
		else $error("clear-all left status or alert set");
	a_alert_on: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(vout_reg[B_TOP] && !mask_reg[MI_VOUT][B_TOP]) |=> !alert_oe_n_o)
		else $error("unmasked fault did not assert alert");
	a_alert_masked: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(cml_reg != 8'h00 && sum_byte == 8'h02 && sum_hi == 8'h00 &&
		mask_reg[MI_BYTE] == MASK_RST_BYTE &&
		mask_reg[MI_CML] == MASK_RST_CML) |=> alert_oe_n_o)
		else $error("masked fault asserted alert");
	a_vout_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		ov_fault_i |=> vout_reg[B_TOP] && sum_byte[B_OV] && sum_hi[B_VSUM])
		else $error("overvoltage not recorded");
	a_byte_w1c: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(wr_byte && code == CMD_BYTE && mcode[B_TOP] && !busy_edge &&
		!ov_fault_i && !ot_fault_i) |=>
		!busy_reg && $stable(vout_reg) && $stable(temp_reg))
		else $error("status byte write cleared wrong bits");
	a_busy_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		busy_edge |=> busy_reg && sum_word[B_TOP])
		else $error("busy not recorded");
	a_read_vout: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(rd_ok && code == CMD_RD_VOUT) |=> sy_rsp_data_reg == $past(vout_i))
		else $error("voltage read returned wrong value");
	a_bad_cmd: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bad_cmd |=> cml_reg[B_INVCMD] && !sy_rsp_ok_reg ##1 !alert_oe_n_o ||
		mask_reg[MI_CML][B_INVCMD])
		else $error("unknown command not flagged");
	a_mask_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(mask_wr && !bad_data && mcode == CMD_VOUT_ST) |=>
		mask_reg[MI_VOUT] == $past(lk_data_reg[15:8]))
		else $error("mask write not stored");
	a_fan_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(wr_byte && code == CMD_FAN_ST && mcode[B_TOP] && !fan_fault_i) |=>
		!fan_reg[B_TOP] && !sum_hi[B_FSUM])
		else $error("fan fault did not clear");
endmodule
`default_nettype wire

//--- pbs_host_model.sv
// host side model of the link: issues one decoded request at a time
// assumes the bank answers every accepted request within a few hundred ns
`timescale 1ns/10ps
`default_nettype none
module pbs_host_model
(
	// link side
	input wire logic link_clk_i,
	input wire logic req_ready_i,
	input wire logic ans_valid_i,
	output pbs_pkg::pbs_op_t req_op_o,
	output logic req_valid_o,
	output logic [7:0] req_code_o,
	output logic [15:0] req_data_o,
	output logic req_pec_err_o
);
	import pbs_pkg::*;
	int timeouts;

	initial
	begin
		timeouts = 0;
		req_valid_o = 1'b0;
		req_op_o = OP_SEND;
		req_code_o = 8'h00;
		req_data_o = 16'h0000;
		req_pec_err_o = 1'b0;
	end

	// ==========================================================
	// answer wait, bounded
	task automatic wait_ans();
		int n;
		n = 0;
		do
		begin
			@(negedge link_clk_i);
			n++;
		end
		while (ans_valid_i !== 1'b1 && n < 500);
		if (ans_valid_i !== 1'b1)
			timeouts++;
	endtask

	// ==========================================================
	// request; mode 0 waits for the answer, 1 returns once taken,
	// 2 fires only while the bank is busy
	task automatic request(input pbs_op_t op, input logic [7:0] code,
		input logic [15:0] data, input logic pec, input int mode);
		int n;
		n = 0;
		do
		begin
			@(negedge link_clk_i);
			n++;
		end
		while (((req_ready_i === 1'b1) == (mode == 2)) && n < 500);
		if ((req_ready_i === 1'b1) == (mode == 2))
			timeouts++;
		req_valid_o = 1'b1;
		req_op_o = op;
		req_code_o = code;
		req_data_o = data;
		req_pec_err_o = pec;
		@(posedge link_clk_i);
		@(negedge link_clk_i);
		// released code and data lines must not keep the last value
		req_valid_o = 1'b0;
		req_code_o = ~code;
		req_data_o = ~data;
		req_pec_err_o = 1'b0;
		if (mode == 0)
			wait_ans();
	endtask
endmodule
`default_nettype wire

//--- test_pmbus_status_alert_monitor_bank.sv
// self-checking bench for the status, alert mask and telemetry bank
// assumes pbs_host_model drives the link side
`timescale 1ns/10ps
`default_nettype none
module test_pmbus_status_alert_monitor_bank;
	import pbs_pkg::*;
	localparam logic [7:0] MC [8] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7D,
		8'h7E, 8'h80, 8'h81};
	localparam logic [7:0] MR [8] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
		8'hFF, 8'h00, 8'h00};
	localparam logic [7:0] FC [10] = '{8'h7A, 8'h7B, 8'h7B, 8'h7D, 8'h81,
		8'h80, 8'h80, 8'h80, 8'h7E, 8'h79};
	localparam logic [15:0] FD [10] = '{16'h0080, 16'h0080, 16'h0020,
		16'h0080, 16'h0080, 16'h0004, 16'h0002, 16'h0001, 16'h0008,
		16'h0100};
	localparam logic [15:0] FW [10] = '{16'h8020, 16'h4010, 16'h4000,
		16'h0004, 16'h0400, 16'h1000, 16'h1000, 16'h1000, 16'h0002,
		16'h0100};
	localparam pbs_op_t EO [4] = '{OP_RD, OP_MASK_RD, OP_WR_BYTE, OP_RD};
	localparam logic [7:0] EC [4] = '{8'h55, 8'h1B, 8'h8B, 8'h8B};
	localparam logic [7:0] EX [4] = '{8'h80, 8'h40, 8'h02, 8'h20};
	logic clk, lclk, rst_n, req_valid, req_pec, ready, ans_v, ans_ok;
	logic alert, alert_oe_n;
	pbs_op_t req_op;
	logic [7:0] req_code;
	logic [15:0] req_data, ans_data;
	logic [9:0] flt;
	logic [15:0] rdg [5];
	logic [16:0] e;
	logic [16:0] expq [$];
	int failures, n_compared, cycles;

	pbs_status_bank i_pbs_status_bank (.clk_sys_i(clk), .rst_n_i(rst_n),
		.link_clk_i(lclk), .req_valid_i(req_valid), .req_op_i(req_op),
		.req_code_i(req_code), .req_data_i(req_data),
		.req_pec_err_i(req_pec), .req_ready_o(ready), .ans_valid_o(ans_v),
		.ans_ok_o(ans_ok), .ans_data_o(ans_data), .ov_fault_i(flt[0]),
		.oc_fault_i(flt[1]), .over_rated_i(flt[2]), .ot_fault_i(flt[3]),
		.fan_fault_i(flt[4]), .derate_stop_i(flt[5]),
		.pulse_stop_i(flt[6]), .sense_stop_i(flt[7]),
		.proc_fault_i(flt[8]), .other_fault_i(flt[9]), .vout_i(rdg[0]),
		.iout_i(rdg[1]), .pout_i(rdg[2]), .fan_speed_i(rdg[3]),
		.temp_i(rdg[4]), .alert_o(alert), .alert_oe_n_o(alert_oe_n));

	pbs_host_model i_pbs_host_model (.link_clk_i(lclk),
		.req_ready_i(ready), .ans_valid_i(ans_v), .req_op_o(req_op),
		.req_valid_o(req_valid), .req_code_o(req_code),
		.req_data_o(req_data), .req_pec_err_o(req_pec));

	// ==========================================================
	// clocks and watchdog
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial
	begin
		lclk = 1'b0;
		#1.7;
		forever #3 lclk = ~lclk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			report_and_stop();
		end
	end

	// ==========================================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task automatic report_and_stop();
		failures += i_pbs_host_model.timeouts;
		if (failures == 0 && n_compared > 0 && expq.size() == 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic xfer(input pbs_op_t op, input logic [7:0] code,
		input logic [15:0] data, input logic ok, input logic [15:0] exp);
		expq.push_back({ok, exp});
		i_pbs_host_model.request(op, code, data, 1'b0, 0);
	endtask

	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		xfer(OP_RD, code, 16'h0000, 1'b1, exp);
	endtask

	task automatic pulse(input int i);
		flt[i] = 1'b1;
		@(negedge clk);
		flt[i] = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	task automatic alert_is(input logic exp_n, input string what);
		repeat (3) @(negedge clk);
		chk({15'h0000, alert_oe_n}, {15'h0000, exp_n}, what);
		chk({15'h0000, alert}, 16'h0000, "alert data");
	endtask

	// ==========================================================
	// answer watcher
	always @(negedge lclk)
		if (ans_v === 1'b1)
		begin
			if (expq.size() == 0)
				chk(16'hFFFF, 16'h0000, "stray answer");
			else
			begin
				e = expq.pop_front();
				chk({15'h0000, ans_ok}, {15'h0000, e[16]}, "ok");
				chk(ans_data, e[15:0], "data");
			end
		end

	// ==========================================================
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		flt = 10'h000;
		failures = 0;
		n_compared = 0;
		cycles = 0;
		for (int i = 0; i < 5; i++)
			rdg[i] = 16'h0000;
		void'($urandom(32'h86fbc1ef));
		repeat (4) @(negedge clk);
		chk({12'h000, alert, ready, ans_v, ans_ok}, 16'h0004, "reset");
		chk(ans_data, 16'h0000, "reset data");
		rst_n = 1'b1;
		chk({15'h0000, alert_oe_n}, 16'h0001, "alert idle");
		for (int i = 0; i < 8; i++)
		begin
			xfer(OP_MASK_RD, CMD_MASK, {8'h00, MC[i]}, 1'b1, {8'h00, MR[i]});
			rd(MC[i], 16'h0000);
		end
		@(negedge clk);
		for (int i = 0; i < 5; i++)
			rdg[i] = 16'($urandom());
		rd(CMD_RD_VOUT, rdg[0]);
		rd(CMD_RD_IOUT, rdg[1]);
		rd(CMD_RD_POUT, rdg[2]);
		rd(CMD_RD_FAN, rdg[3]);
		rd(CMD_RD_TEMP, rdg[4]);
		// every fault source, cleared alternately
		for (int i = 0; i < 10; i++)
		begin
			@(negedge clk);
			pulse(i);
			alert_is(i == 8, "alert on fault");
			rd(FC[i], FD[i]);
			rd(CMD_WORD, FW[i]);
			rd(CMD_BYTE, {8'h00, FW[i][7:0]});
			if (i[0])
				xfer(OP_SEND, CMD_CLEAR, 16'h0000, 1'b1, 16'h0000);
			else
				xfer(OP_WR_BYTE, FC[i], FD[i], 1'b1, 16'h0000);
			alert_is(1'b1, "alert after clear");
			rd(CMD_WORD, 16'h0000);
		end
		// refused request, busy bit and partial clears
		expq.push_back({1'b1, rdg[0]});
		i_pbs_host_model.request(OP_RD, CMD_RD_VOUT, 16'h0000, 1'b0, 1);
		i_pbs_host_model.request(OP_RD, CMD_RD_IOUT, 16'h0000, 1'b0, 2);
		i_pbs_host_model.wait_ans();
		@(negedge clk);
		pulse(1);
		pulse(9);
		rd(CMD_BYTE, 16'h0090);
		xfer(OP_WR_BYTE, CMD_BYTE, 16'h00FF, 1'b1, 16'h0000);
		rd(CMD_BYTE, 16'h0010);
		rd(CMD_WORD, 16'h4110);
		xfer(OP_WR_WORD, CMD_WORD, 16'hFFFF, 1'b1, 16'h0000);
		rd(CMD_WORD, 16'h4010);
		xfer(OP_SEND, CMD_CLEAR, 16'h0000, 1'b1, 16'h0000);
		// masks: voltage fault recorded but kept off the alert
		xfer(OP_WR_WORD, CMD_MASK, 16'h807A, 1'b1, 16'h0000);
		xfer(OP_WR_WORD, CMD_MASK, 16'h2278, 1'b1, 16'h0000);
		xfer(OP_WR_WORD, CMD_MASK, 16'h8079, 1'b1, 16'h0000);
		xfer(OP_MASK_RD, CMD_MASK, 16'h007A, 1'b1, 16'h0080);
		@(negedge clk);
		pulse(0);
		alert_is(1'b1, "masked fault");
		rd(CMD_VOUT_ST, 16'h0080);
		@(negedge clk);
		pulse(1);
		alert_is(1'b0, "unmasked fault");
		xfer(OP_SEND, CMD_CLEAR, 16'h0000, 1'b1, 16'h0000);
		alert_is(1'b1, "clear releases");
		rd(CMD_VOUT_ST, 16'h0000);
		// link errors land in the communication status
		for (int i = 0; i < 4; i++)
		begin
			expq.push_back({1'b0, 16'h0000});
			i_pbs_host_model.request(EO[i], EC[i], 16'h0042, i == 3, 0);
			rd(CMD_CML_ST, {8'h00, EX[i]});
			rd(CMD_BYTE, 16'h0002);
			alert_is(1'b1, "comm masked");
			xfer(OP_WR_BYTE, CMD_CML_ST, {8'h00, EX[i]}, 1'b1, 16'h0000);
		end
		rd(CMD_BYTE, 16'h0000);
		repeat (5) @(negedge clk);
		report_and_stop();
	end
endmodule
`default_nettype wire
